// [pkg/ufec_pkg.sv]
// Shared constants and carriers of the serial frame and enable control block.
package ufec_pkg;
	// Byte offsets of the registers on the bus.
	localparam logic [4:0] OFS_FRAME = 5'h00;
	localparam logic [4:0] OFS_CTRL = 5'h04;
	localparam logic [4:0] OFS_STATUS = 5'h08;
	localparam logic [4:0] OFS_DATA = 5'h0C;
	localparam logic [4:0] OFS_AUX = 5'h10;
	// Reset values of the two control registers and the auxiliary register.
	localparam logic [7:0] RST_FRAME = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic RST_DIR = 1'b0;
	// Writable bits of the enable register; the two low bits read as zero.
	localparam logic [7:0] CTRL_WMASK = 8'hFC;
	// Bit positions inside the status register.
	localparam int ST_TX_BUFFER_EMPTY = 7;
	localparam int ST_TC = 6;
	localparam int ST_RX_BUFFER_FULL = 5;
	localparam int ST_IDLE = 4;
	localparam int ST_PERR = 1;
	localparam int ST_FERR = 0;
	// Oversampling: sixteen ticks per bit, sampled at the middle.
	localparam logic [3:0] OS_LAST = 4'hF;
	localparam logic [3:0] OS_MID = 4'h7;
	// Data bits per character in 8-bit and 9-bit modes.
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] BITS_9 = 4'h9;
	// Idle line length in ticks: 10 or 11 bit times of 16 ticks.
	localparam logic [8:0] IDLE_TICKS_8 = 9'h0A0;
	localparam logic [8:0] IDLE_TICKS_9 = 9'h0B0;

	// Frame and mode control register, bit 7 first.
	typedef struct packed {
		logic loop_select;
		logic wait_freeze;
		logic receiver_source;
		logic nine_bit_mode;
		logic wake_address_mark;
		logic idle_type;
		logic parity_on;
		logic parity_odd_select;
	} ufec_frame_t;

	// Interrupt and enable control register, bit 7 first.
	typedef struct packed {
		logic tx_empty_irq_en;
		logic tx_done_irq_en;
		logic rx_full_irq_en;
		logic idle_irq_en;
		logic tx_enable;
		logic rx_on;
		logic [1:0] reserved;
	} ufec_ctrl_t;
endpackage

// [logic/ufec_tick_div.sv]
`timescale 1ns/1ps
// Divides the clock down to a one-cycle oversampling tick.
module ufec_tick_div #(
	parameter int DIV = 108
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Tick output, one cycle wide.
	output logic tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] CNT_LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_ff; // Cycles since the last tick.
	logic wrap; // High in the last cycle of a period.

	assign wrap = (cnt_ff == CNT_LAST);
	assign tick = wrap;

	// The counter wraps after DIV cycles.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= wrap ? '0 : cnt_ff + CW'(1);
		end
	end
endmodule // ufec_tick_div

// [logic/ufec_parity.sv]
`timescale 1ns/1ps
// Parity over a character whose top data bit is the parity bit.
module ufec_parity (
	// Character and format.
	input wire logic [8:0] data,
	input wire logic nine_bit,
	input wire logic odd,
	// Parity bit to send and check result.
	output logic gen_bit,
	output logic bad
);
	logic low_ones; // Parity of the bits below the parity bit.
	logic all_ones; // Parity of the whole character.

	assign low_ones = nine_bit ? ^data[7:0] : ^data[6:0];
	assign all_ones = nine_bit ? ^data[8:0] : ^data[7:0];
	// Odd parity needs an odd total, so the bit equals the low parity inverted.
	assign gen_bit = low_ones ^ odd;
	assign bad = (all_ones != odd);
endmodule // ufec_parity

// [logic/ufec_top.sv]
`timescale 1ns/1ps
// Functional notes
// - Loop select routes transmitter output into receiver.
// - Loop select clear gives normal two-pin operation.
// - Wait freeze stops serial clocks during wait.
// - Receiver source ignored unless loop select set.
// - Loop without source bit is internal loopback.
// - Loop with source bit shares transmit pin.
// - Character length bit picks eight or nine bits.
// - Wake method picks idle or address-mark wakeup.
// - Idle type picks where idle counting starts.
// - Parity on generates and checks MSB parity.
// - Parity type picks even or odd parity.
// - Transmit-empty enable requests interrupt on empty flag.
// - Done enable requests interrupt on complete flag.
// - Receive enable requests interrupt on full flag.
// - Idle enable requests interrupt on idle flag.
// - Transmitter runs and drives pin when enabled.
// - Direction bit steers shared pin in single-wire.
// - Enable toggled during transmission queues idle character.
// - Pin held until pending frame finishes after disable.
// - Receive pin released when off or looped.
// - Empty flag set at reset and on load.
module ufec_top #(
	parameter int CLK_PER_TICK = 108
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Processor state.
	input wire logic cpu_wait,
	// Serial pins.
	input wire logic rxd_in,
	input wire logic txd_in,
	output logic txd_out,
	output logic txd_oe,
	// Pin ownership, interrupt request and wakeup.
	output logic rx_pin_owned,
	output logic tx_pin_owned,
	output logic irq_request,
	output logic wakeup_event
);
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_IDLECHAR} ufec_tx_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufec_rx_t;

	ufec_pkg::ufec_frame_t frame_ff; // Frame and mode control register.
	ufec_pkg::ufec_ctrl_t ctrl_ff; // Interrupt and enable control register.
	logic dir_ff; // Single-wire direction, 1 drives the shared pin.
	logic ack_ff; // Bus acknowledge.
	logic [31:0] rdat_ff; // Registered read data.
	logic [8:0] hold_ff; // Transmit buffer.
	logic tx_buffer_empty_ff; // Transmit buffer empty.
	logic tc_ff; // Transmission complete.
	logic rx_buffer_full_ff; // Receive buffer full.
	logic idle_ff; // Idle line seen.
	logic perr_ff; // Parity error of the last character.
	logic ferr_ff; // Framing error of the last character.
	logic idle_pend_ff; // Idle character waiting to be sent.
	ufec_tx_t tx_state_ff; // Transmitter state.
	logic [3:0] tx_os_ff; // Tick within the current transmit bit.
	logic [3:0] tx_bit_ff; // Bit index within the transmit frame.
	logic [8:0] tx_shift_ff; // Transmit shifter.
	logic tx_line_ff; // Transmitter output level.
	ufec_rx_t rx_state_ff; // Receiver state.
	logic [3:0] rx_os_ff; // Tick within the current receive bit.
	logic [3:0] rx_bit_ff; // Received data bits so far.
	logic [8:0] rx_shift_ff; // Receive shifter.
	logic [8:0] rx_data_ff; // Received character.
	logic [8:0] idle_cnt_ff; // Ticks of high line counted.
	logic idle_arm_ff; // Idle may be flagged once after activity.

	// Bus decode.
	wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire wr = req & wb_we_i & wb_sel_i[0];
	wire rd = req & ~wb_we_i;
	wire hit_frame = (wb_adr_i == ufec_pkg::OFS_FRAME);
	wire hit_ctrl = (wb_adr_i == ufec_pkg::OFS_CTRL);
	wire hit_status = (wb_adr_i == ufec_pkg::OFS_STATUS);
	wire hit_data = (wb_adr_i == ufec_pkg::OFS_DATA);
	wire hit_aux = (wb_adr_i == ufec_pkg::OFS_AUX);
	wire [7:0] ctrl_wr = wb_dat_i[7:0] & ufec_pkg::CTRL_WMASK;
	wire data_wr = wr & hit_data;
	wire data_rd = rd & hit_data;
	// A 0-to-1 write of the enable while a frame is running queues an idle.
	wire tx_busy = (tx_state_ff != TX_IDLE);
	wire te_rise = wr & hit_ctrl & ctrl_wr[3] & ~ctrl_ff.tx_enable;
	wire [7:0] status = {tx_buffer_empty_ff, tc_ff, rx_buffer_full_ff, idle_ff, 2'b00, perr_ff, ferr_ff};
	wire [8:0] rd_sel = hit_frame ? {1'b0, frame_ff} :
		hit_ctrl ? {1'b0, ctrl_ff} :
		hit_status ? {1'b0, status} :
		hit_data ? rx_data_ff :
		hit_aux ? {8'h00, dir_ff} : 9'h000;

	// Serial timing; the tick is held back while frozen in wait mode.
	wire raw_tick;
	wire ser_tick = raw_tick & ~(cpu_wait & frame_ff.wait_freeze);
	wire [3:0] nbits = frame_ff.nine_bit_mode ? ufec_pkg::BITS_9 : ufec_pkg::BITS_8;
	wire [3:0] idle_bits = nbits + 4'h1;
	wire tx_bit_end = ser_tick & (tx_os_ff == ufec_pkg::OS_LAST);

	// Routing of the receiver input.
	wire single_wire = frame_ff.loop_select & frame_ff.receiver_source;
	wire rx_line = ~frame_ff.loop_select ? rxd_in :
		frame_ff.receiver_source ? txd_in :
		tx_line_ff;

	// Transmitter parity and buffer load.
	wire tx_gen_par;
	wire tx_bad_unused;
	wire par_msb_8 = frame_ff.parity_on ? tx_gen_par : hold_ff[7];
	wire par_msb_9 = frame_ff.parity_on ? tx_gen_par : hold_ff[8];
	wire [8:0] tx_char = frame_ff.nine_bit_mode ? {par_msb_9, hold_ff[7:0]} :
		{1'b0, par_msb_8, hold_ff[6:0]};
	wire tx_start_idle = ~tx_busy & ser_tick & idle_pend_ff;
	wire tx_load = ~tx_busy & ser_tick & ~idle_pend_ff & ctrl_ff.tx_enable & ~tx_buffer_empty_ff;
	wire tc_set = tx_buffer_empty_ff & ~tx_busy & ~idle_pend_ff;

	// Receiver sampling, parity check and idle detection.
	wire rx_done = ser_tick & (rx_state_ff == RX_STOP) & (rx_os_ff == ufec_pkg::OS_LAST);
	wire [8:0] rx_char = frame_ff.nine_bit_mode ? rx_shift_ff : {1'b0, rx_shift_ff[8:1]};
	wire rx_gen_unused;
	wire rx_bad;
	wire [8:0] idle_limit = frame_ff.nine_bit_mode ? ufec_pkg::IDLE_TICKS_9 :
		ufec_pkg::IDLE_TICKS_8;
	// With idle type set the count is held at zero for the whole frame.
	wire idle_clr = ~rx_line | (frame_ff.idle_type & (rx_state_ff != RX_IDLE));
	wire idle_full = (idle_cnt_ff == idle_limit);
	wire idle_hit = idle_full & idle_arm_ff & ctrl_ff.rx_on;

	ufec_tick_div #(
		.DIV(CLK_PER_TICK)
	) u_tick (
		.clock(clock),
		.rst_n(rst_n),
		.tick(raw_tick)
	);

	ufec_parity u_tx_par (
		.data(hold_ff),
		.nine_bit(frame_ff.nine_bit_mode),
		.odd(frame_ff.parity_odd_select),
		.gen_bit(tx_gen_par),
		.bad(tx_bad_unused)
	);

	ufec_parity u_rx_par (
		.data(rx_char),
		.nine_bit(frame_ff.nine_bit_mode),
		.odd(frame_ff.parity_odd_select),
		.gen_bit(rx_gen_unused),
		.bad(rx_bad)
	);

	// Outputs toward the pins and the processor.
	assign wb_dat_o = rdat_ff;
	assign wb_ack_o = ack_ff;
	assign txd_out = tx_line_ff;
	// The pin stays ours until the running frame and any queued idle end.
	assign tx_pin_owned = ctrl_ff.tx_enable | tx_busy | idle_pend_ff;
	assign txd_oe = tx_pin_owned & (~single_wire | dir_ff);
	assign rx_pin_owned = ctrl_ff.rx_on & ~frame_ff.loop_select;
	assign irq_request = (ctrl_ff.tx_empty_irq_en & tx_buffer_empty_ff) |
		(ctrl_ff.tx_done_irq_en & tc_ff) |
		(ctrl_ff.rx_full_irq_en & rx_buffer_full_ff) |
		(ctrl_ff.idle_irq_en & idle_ff);
	assign wakeup_event = frame_ff.wake_address_mark ? (rx_done & rx_shift_ff[8]) : idle_hit;

	// Bus slave: one wait state, then acknowledge with registered data.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
			rdat_ff <= '0;
		end else begin
			ack_ff <= req;
			if (rd) begin
				rdat_ff <= {23'h000000, rd_sel};
			end
		end
	end

	// Control registers, written from byte lane 0.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			frame_ff <= ufec_pkg::RST_FRAME;
			ctrl_ff <= ufec_pkg::RST_CTRL;
			dir_ff <= ufec_pkg::RST_DIR;
		end else if (wr) begin
			if (hit_frame) begin
				frame_ff <= wb_dat_i[7:0];
			end
			if (hit_ctrl) begin
				ctrl_ff <= ctrl_wr;
			end
			if (hit_aux) begin
				dir_ff <= wb_dat_i[0];
			end
		end
	end

	// Transmit buffer and flags; a set in the same cycle as a clear wins.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hold_ff <= '0;
			tx_buffer_empty_ff <= 1'b1;
			tc_ff <= 1'b1;
			idle_pend_ff <= 1'b0;
		end else begin
			if (data_wr) begin
				hold_ff <= {wb_sel_i[1] & wb_dat_i[8], wb_dat_i[7:0]};
			end
			tx_buffer_empty_ff <= tx_load | (tx_buffer_empty_ff & ~data_wr);
			tc_ff <= tc_set;
			idle_pend_ff <= (te_rise & tx_busy) | (idle_pend_ff & ~tx_start_idle);
		end
	end

	// Transmitter: start, data LSB first, stop, or a frame of all ones.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_ff <= TX_IDLE;
			tx_os_ff <= '0;
			tx_bit_ff <= '0;
			tx_shift_ff <= '0;
			tx_line_ff <= 1'b1;
		end else if (ser_tick) begin
			tx_os_ff <= tx_busy ? tx_os_ff + 4'h1 : 4'h0;
			case (tx_state_ff)
				TX_IDLE: begin
					tx_bit_ff <= '0;
					if (tx_start_idle) begin
						tx_state_ff <= TX_IDLECHAR;
					end else if (tx_load) begin
						tx_state_ff <= TX_START;
						tx_shift_ff <= tx_char;
						tx_line_ff <= 1'b0;
					end
				end
				TX_START: begin
					if (tx_bit_end) begin
						tx_state_ff <= TX_DATA;
						tx_line_ff <= tx_shift_ff[0];
						tx_shift_ff <= {1'b0, tx_shift_ff[8:1]};
						tx_bit_ff <= 4'h1;
					end
				end
				TX_DATA: begin
					if (tx_bit_end && tx_bit_ff == nbits) begin
						tx_state_ff <= TX_STOP;
						tx_line_ff <= 1'b1;
					end else if (tx_bit_end) begin
						tx_line_ff <= tx_shift_ff[0];
						tx_shift_ff <= {1'b0, tx_shift_ff[8:1]};
						tx_bit_ff <= tx_bit_ff + 4'h1;
					end
				end
				TX_STOP: begin
					if (tx_bit_end) begin
						tx_state_ff <= TX_IDLE;
					end
				end
				TX_IDLECHAR: begin
					// Ten or eleven bit times of high line.
					if (tx_bit_end && tx_bit_ff == idle_bits) begin
						tx_state_ff <= TX_IDLE;
					end else if (tx_bit_end) begin
						tx_bit_ff <= tx_bit_ff + 4'h1;
					end
				end
				default: begin
					tx_state_ff <= TX_IDLE;
				end
			endcase
		end
	end

	// Receiver: find the start bit, then sample each bit at its middle.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_ff <= RX_IDLE;
			rx_os_ff <= '0;
			rx_bit_ff <= '0;
			rx_shift_ff <= '0;
		end else if (ser_tick) begin
			rx_os_ff <= rx_os_ff + 4'h1;
			case (rx_state_ff)
				RX_IDLE: begin
					rx_os_ff <= '0;
					rx_bit_ff <= '0;
					if (ctrl_ff.rx_on && !rx_line) begin
						rx_state_ff <= RX_START;
					end
				end
				RX_START: begin
					// A start bit that is gone by its middle was a glitch.
					if (rx_os_ff == ufec_pkg::OS_MID) begin
						rx_state_ff <= rx_line ? RX_IDLE : RX_DATA;
						rx_os_ff <= '0;
					end
				end
				RX_DATA: begin
					if (rx_os_ff == ufec_pkg::OS_LAST) begin
						rx_shift_ff <= {rx_line, rx_shift_ff[8:1]};
						rx_bit_ff <= rx_bit_ff + 4'h1;
						if (rx_bit_ff == nbits - 4'h1) begin
							rx_state_ff <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_os_ff == ufec_pkg::OS_LAST) begin
						rx_state_ff <= RX_IDLE;
					end
				end
				default: begin
					rx_state_ff <= RX_IDLE;
				end
			endcase
		end
	end

	// Receive flags; reading the data register clears full and idle.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_data_ff <= '0;
			rx_buffer_full_ff <= 1'b0;
			idle_ff <= 1'b0;
			perr_ff <= 1'b0;
			ferr_ff <= 1'b0;
			idle_cnt_ff <= '0;
			idle_arm_ff <= 1'b0;
		end else begin
			if (rx_done) begin
				rx_data_ff <= rx_char;
				perr_ff <= frame_ff.parity_on & rx_bad;
				ferr_ff <= ~rx_line;
			end
			rx_buffer_full_ff <= rx_done | (rx_buffer_full_ff & ~data_rd);
			idle_ff <= idle_hit | (idle_ff & ~data_rd);
			idle_arm_ff <= rx_done | (idle_arm_ff & ~idle_hit);
			if (ser_tick && idle_clr) begin
				idle_cnt_ff <= '0;
			end else if (ser_tick && !idle_full) begin
				idle_cnt_ff <= idle_cnt_ff + 9'h001;
			end
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	AST_LOOPBACK_SRC: assert property (frame_ff.loop_select && !frame_ff.receiver_source |->
		rx_line == tx_line_ff && !rx_pin_owned)
		else $error("loopback does not feed the transmitter into the receiver");
	AST_NORMAL_SRC: assert property (!frame_ff.loop_select |-> rx_line == rxd_in)
		else $error("normal mode does not take the receive pin");
	AST_SINGLE_WIRE: assert property (single_wire |-> rx_line == txd_in &&
		txd_oe == (tx_pin_owned && dir_ff))
		else $error("single-wire pin routing is wrong");
	AST_FREEZE: assert property (cpu_wait && frame_ff.wait_freeze |=>
		$stable(tx_os_ff) && $stable(rx_os_ff))
		else $error("serial logic advanced while frozen");
	AST_IRQ_TX_BUFFER_EMPTY: assert property (ctrl_ff.tx_empty_irq_en && tx_buffer_empty_ff |-> irq_request)
		else $error("empty buffer did not request an interrupt");
	AST_IRQ_NONE: assert property (ctrl_ff[7:4] == 4'h0 |-> !irq_request)
		else $error("interrupt requested with all enables clear");
	AST_RELEASE: assert property (!ctrl_ff.tx_enable && (tx_busy || idle_pend_ff) |->
		tx_pin_owned)
		else $error("transmit pin released before the frame ended");
	AST_QUEUE_IDLE: assert property (te_rise && tx_busy |=> idle_pend_ff)
		else $error("enable toggle did not queue an idle character");
	AST_TX_BUFFER_EMPTY_LOAD: assert property (tx_load |=> tx_buffer_empty_ff && tx_state_ff == TX_START)
		else $error("empty flag not set on buffer load");
	AST_WRITE_BACK: assert property (wr && hit_frame |=> frame_ff == $past(wb_dat_i[7:0]))
		else $error("frame register does not hold written value");
	AST_RX_PARITY: assert property (rx_done && frame_ff.parity_on && !rx_bad |=>
		(^rx_data_ff) == frame_ff.parity_odd_select)
		else $error("accepted character has wrong parity");

	COV_LOOP_CHAR: cover property (frame_ff.loop_select && !frame_ff.receiver_source && rx_done);
	COV_SINGLE_WIRE: cover property (single_wire && rx_done);
	COV_IDLE_QUEUED: cover property (tx_start_idle);
	COV_PARITY_ERR: cover property (rx_done && frame_ff.parity_on && rx_bad);
endmodule // ufec_top

// [tb/ufec_peer.sv]
`timescale 1ns/1ps
// Remote serial peer that sends characters to the block and collects its characters.
module ufec_peer #(
	parameter int BIT_CLKS = 32
) (
	// Bench clock.
	input wire logic clock,
	// Line toward the block and line from the block.
	output logic line_out,
	input wire logic line_in
);
	// The line idles high, as a released pulled-up wire would.
	initial line_out = 1'b1;

	// Sends a start bit, nb data bits LSB first, then a stop bit.
	task automatic send(input logic [8:0] d, input int nb);
		int i;
		@(posedge clock);
		line_out <= 1'b0;
		repeat (BIT_CLKS) @(posedge clock);
		for (i = 0; i < nb; i++) begin
			line_out <= d[i];
			repeat (BIT_CLKS) @(posedge clock);
		end
		line_out <= 1'b1;
		repeat (BIT_CLKS) @(posedge clock);
	endtask

	// Waits a bounded time for a start bit, samples mid-cell, then checks the stop bit.
	task automatic recv(input int nb, output logic [8:0] d, output logic ok);
		int i;
		d = 9'h000;
		ok = 1'b0;
		for (i = 0; i < 40 * BIT_CLKS && line_in !== 1'b0; i++) @(posedge clock);
		if (line_in !== 1'b0) return;
		repeat (BIT_CLKS / 2) @(posedge clock);
		for (i = 0; i < nb; i++) begin
			repeat (BIT_CLKS) @(posedge clock);
			d[i] = line_in;
		end
		repeat (BIT_CLKS) @(posedge clock);
		ok = (line_in === 1'b1);
	endtask
endmodule // ufec_peer

// [tb/ufec_top_tb_top.sv]
`timescale 1ns/1ps
// Compares a value with its expectation and counts the outcome.
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("ERROR %s expected %h seen %h", what, exp, got); end end
// Self-checking bench of the frame and enable control block.
module ufec_top_tb_top;
	localparam int TICK = 2;
	localparam int BIT = TICK * 16;
	// Clock, reset and bus signals, all driven from time zero.
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [4:0] wb_adr_i = 5'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic cpu_wait = 1'b0;
	// Serial lines; the shared pin takes the block's level while it drives.
	logic rxd_line;
	logic txd_in;
	logic txd_out;
	logic txd_oe;
	logic rx_pin_owned;
	logic tx_pin_owned;
	logic irq_request;
	logic wakeup_event;
	int n_wake = 0; // Wakeup pulses seen so far.
	int w0; // Wakeup count at the start of a check.
	int n_mismatch = 0;
	int n_tests = 0;
	logic [31:0] q;
	logic [8:0] d;
	logic ok;
	int bad;
	assign txd_in = txd_oe ? txd_out : rxd_line;

	// Half period of 2.5 ns gives 200 MHz.
	always #2.5 clock = ~clock;

	// Counts the one-cycle wakeup pulses of the block.
	always @(posedge clock) begin
		if (wakeup_event === 1'b1) n_wake <= n_wake + 1;
	end

	ufec_top #(.CLK_PER_TICK(TICK)) ufec_top_i (.clock(clock), .rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.cpu_wait(cpu_wait), .rxd_in(rxd_line), .txd_in(txd_in), .txd_out(txd_out),
		.txd_oe(txd_oe), .rx_pin_owned(rx_pin_owned), .tx_pin_owned(tx_pin_owned),
		.irq_request(irq_request), .wakeup_event(wakeup_event));
	ufec_peer #(.BIT_CLKS(BIT)) ufec_peer_i (.clock(clock), .line_out(rxd_line), .line_in(txd_out));

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// One classic bus cycle, held until ack is sampled, then one idle cycle.
	task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] wd,
		output logic [31:0] rd_q);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= wd;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 64);
		rd_q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (i >= 64) begin
			n_mismatch++;
			$display("ERROR bus ack expected 1 seen 0");
			give_verdict();
		end
		@(posedge clock);
	endtask

	// Writes one byte to a register.
	task automatic wr(input logic [4:0] a, input logic [7:0] wd);
		logic [31:0] x;
		bus(1'b1, a, {24'h000000, wd}, x);
	endtask

	// Polls a status flag a bounded number of times.
	task automatic wait_st(input int b);
		int i;
		for (i = 0; i < 60; i++) begin
			bus(1'b0, ufec_pkg::OFS_STATUS, 32'h00000000, q);
			if (q[b] === 1'b1) break;
			repeat (BIT) @(posedge clock);
		end
		`CHK("status flag", 1'b1, q[b])
	endtask

	// Holds reset for four cycles, then releases it on an edge.
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
	endtask

	// Counts cycles in which the line leaves its idle high level.
	task automatic count_low(input int n);
		bad = 0;
		repeat (n) begin
			@(posedge clock);
			if (txd_out !== 1'b1) bad++;
		end
	endtask

	// Reset values, read-back, unmapped space and interrupt enables.
	task automatic t_regs();
		do_reset();
		bus(1'b0, ufec_pkg::OFS_FRAME, 32'h0, q);
		`CHK("frame reset", 8'h00, q[7:0])
		bus(1'b0, ufec_pkg::OFS_CTRL, 32'h0, q);
		`CHK("ctrl reset", 8'h00, q[7:0])
		bus(1'b0, ufec_pkg::OFS_STATUS, 32'h0, q);
		`CHK("empty flags", 2'b11, q[7:6])
		`CHK("pin idle", 2'b01, {txd_oe, txd_out})
		wr(ufec_pkg::OFS_FRAME, 8'hA5);
		bus(1'b0, ufec_pkg::OFS_FRAME, 32'h0, q);
		`CHK("frame rw", 8'hA5, q[7:0])
		wr(ufec_pkg::OFS_CTRL, 8'hF3);
		bus(1'b0, ufec_pkg::OFS_CTRL, 32'h0, q);
		`CHK("ctrl rw", 8'hF3 & ufec_pkg::CTRL_WMASK, q[7:0])
		bus(1'b0, 5'h18, 32'h0, q);
		`CHK("unmapped", 32'h00000000, q)
		wr(ufec_pkg::OFS_CTRL, 8'h80);
		`CHK("irq empty", 1'b1, irq_request)
		wr(ufec_pkg::OFS_CTRL, 8'h40);
		`CHK("irq done", 1'b1, irq_request)
		wr(ufec_pkg::OFS_CTRL, 8'h30);
		`CHK("irq masked", 1'b0, irq_request)
		$display("test regs done");
	endtask

	// Transmit with parity off, even and odd; held data waits while disabled.
	task automatic t_tx();
		int k;
		logic [7:0] e;
		for (k = 0; k < 3; k++) begin
			do_reset();
			wr(ufec_pkg::OFS_FRAME, {6'h00, k != 0, k == 2});
			bus(1'b1, ufec_pkg::OFS_DATA, 32'h83, q);
			count_low(3 * BIT);
			`CHK("held while off", 0, bad)
			e = (k == 0) ? 8'h83 : {(^7'h03) ^ (k == 2), 7'h03};
			fork
				ufec_peer_i.recv(8, d, ok);
				wr(ufec_pkg::OFS_CTRL, 8'h08);
			join
			`CHK("tx char", {1'b1, e}, {ok, d[7:0]})
			`CHK("tx drives", 2'b11, {txd_oe, tx_pin_owned})
		end
		$display("test tx done");
	endtask

	// Two-pin receive with a 9-bit character, receive and idle interrupts.
	task automatic t_rx();
		do_reset();
		wr(ufec_pkg::OFS_FRAME, 8'h30);
		wr(ufec_pkg::OFS_CTRL, 8'h24);
		w0 = n_wake;
		`CHK("rx pin owned", 1'b1, rx_pin_owned)
		ufec_peer_i.send(9'h1A5, 9);
		wait_st(ufec_pkg::ST_RX_BUFFER_FULL);
		`CHK("irq rx full", 1'b1, irq_request)
		wr(ufec_pkg::OFS_CTRL, 8'h14);
		repeat (14 * BIT) @(posedge clock);
		`CHK("irq idle", 1'b1, irq_request)
		`CHK("idle wakeup", w0 + 1, n_wake)
		bus(1'b0, ufec_pkg::OFS_DATA, 32'h0, q);
		`CHK("rx char", 9'h1A5, q[8:0])
		@(posedge clock);
		`CHK("irq cleared", 1'b0, irq_request)
		wr(ufec_pkg::OFS_FRAME, 8'hB0);
		`CHK("rx pin freed", 1'b0, rx_pin_owned)
		$display("test rx done");
	endtask

	// Internal loopback with odd parity and mark wakeup ignores the receive pin.
	task automatic t_loop();
		do_reset();
		wr(ufec_pkg::OFS_FRAME, 8'h8B);
		wr(ufec_pkg::OFS_CTRL, 8'h0C);
		w0 = n_wake;
		fork
			ufec_peer_i.send(9'h000, 8);
			bus(1'b1, ufec_pkg::OFS_DATA, 32'h3C, q);
		join
		wait_st(ufec_pkg::ST_RX_BUFFER_FULL);
		`CHK("loop parity ok", 1'b0, q[ufec_pkg::ST_PERR])
		bus(1'b0, ufec_pkg::OFS_DATA, 32'h0, q);
		`CHK("loop char", {~(^7'h3C), 7'h3C}, q[7:0])
		`CHK("mark wakeup", w0 + 1, n_wake)
		$display("test loop done");
	endtask

	// Single-wire receive on the shared pin and direction control.
	task automatic t_single();
		do_reset();
		wr(ufec_pkg::OFS_FRAME, 8'hA0);
		wr(ufec_pkg::OFS_AUX, 8'h00);
		wr(ufec_pkg::OFS_CTRL, 8'h04);
		`CHK("pin listens", 1'b0, txd_oe)
		ufec_peer_i.send(9'h04B, 8);
		wait_st(ufec_pkg::ST_RX_BUFFER_FULL);
		bus(1'b0, ufec_pkg::OFS_DATA, 32'h0, q);
		`CHK("single wire char", 8'h4B, q[7:0])
		wr(ufec_pkg::OFS_CTRL, 8'h0C);
		`CHK("pin held off", 1'b0, txd_oe)
		wr(ufec_pkg::OFS_AUX, 8'h01);
		`CHK("pin drives", 1'b1, txd_oe)
		$display("test single done");
	endtask

	// Disabling mid-frame keeps the pin; a toggle queues one idle character.
	task automatic t_release();
		int i;
		do_reset();
		wr(ufec_pkg::OFS_CTRL, 8'h08);
		fork
			ufec_peer_i.recv(8, d, ok);
			begin
				bus(1'b1, ufec_pkg::OFS_DATA, 32'h5A, q);
				repeat (3 * BIT) @(posedge clock);
				wr(ufec_pkg::OFS_CTRL, 8'h00);
				`CHK("pin kept", 2'b11, {tx_pin_owned, txd_oe})
				wr(ufec_pkg::OFS_CTRL, 8'h08);
				wr(ufec_pkg::OFS_CTRL, 8'h00);
			end
		join
		`CHK("frame finished", 9'h15A, {ok, d[7:0]})
		count_low(2 * BIT);
		`CHK("idle line high", 0, bad)
		`CHK("idle queued", 1'b1, tx_pin_owned)
		for (i = 0; i < 16 * BIT && tx_pin_owned !== 1'b0; i++) @(posedge clock);
		`CHK("pin returned", 1'b0, tx_pin_owned)
		$display("test release done");
	endtask

	// Frozen clocks in wait hold the transmitter; it resumes after wait.
	task automatic t_wait();
		do_reset();
		wr(ufec_pkg::OFS_FRAME, 8'h40);
		cpu_wait <= 1'b1;
		wr(ufec_pkg::OFS_CTRL, 8'h08);
		bus(1'b1, ufec_pkg::OFS_DATA, 32'h11, q);
		count_low(3 * BIT);
		`CHK("frozen", 0, bad)
		cpu_wait <= 1'b0;
		ufec_peer_i.recv(8, d, ok);
		`CHK("after wait", 9'h111, {ok, d[7:0]})
		$display("test wait done");
	endtask

	// Main sequence; every test starts from a fresh reset.
	initial begin
		t_regs();
		t_tx();
		t_rx();
		t_loop();
		t_single();
		t_release();
		t_wait();
		give_verdict();
	end
endmodule // ufec_top_tb_top
